/* hdl/rsm_pkg.sv */
// Purpose: Shared constants and types for the rail sequence slot monitor.
// Assumes: 100 MHz clock, 8-bit register data, 10-bit register address.
// Notes:   The package holds every offset, field position and count.
package rsm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [9:0] ADDR_ORDER = 10'h232;
  localparam logic [9:0] ADDR_SLOT1 = 10'h233;
  localparam logic [9:0] ADDR_SLOT2 = 10'h234;
  localparam logic [9:0] ADDR_SLOT3 = 10'h235;
  localparam logic [9:0] ADDR_TEST = 10'h240;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int RAIL4_LSB = 4;
  localparam int RAIL3_LSB = 0;
  localparam int FORCE_BIT = 0;
  localparam logic [2:0] ORDER_OFF = 3'h0;
  localparam logic [2:0] ORDER_FIRST = 3'h1;
  localparam logic [2:0] ORDER_MAX = 3'h5;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RSM_IDLE = 2'b01,
    RSM_RUN = 2'b10
  } rsm_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rsm_reg_req_t;

  typedef struct packed {
    logic buck_boost_rail;
    logic linear_rail_three;
    logic linear_rail_four;
    logic slot_boundary;
  } rsm_rails_t;

endpackage

/* hdl/rsm_slot_timer.sv */
// Purpose: Saturating 8-bit count of measurement ticks for one slot.
// Assumes: tick is a one-cycle pulse; clear starts a new sequence.
// Notes:   The count holds once active drops until the next clear.
`timescale 1ns/1ps
`default_nettype none
module rsm_slot_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic active,
  input wire logic tick,
  output logic [7:0] count
);

  typedef struct packed {
    logic [7:0] count;
  } rsm_timer_st_t;

  rsm_timer_st_t st;
  rsm_timer_st_t next_st;

  // Clear wins, then count ticks while the slot runs, stopping at 255.
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.count = rsm_pkg::RESET_VALUE;
    end else if (active && tick && st.count != rsm_pkg::COUNT_MAX) begin
      next_st.count = st.count + 8'h01;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign count = st.count;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_timer_step;
    @(posedge clk) disable iff (!rst_b)
    ce && !clear && active && tick && count != 8'hff |=> count == $past(count) + 8'h01;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer missed a tick");

  property p_timer_sat;
    @(posedge clk) disable iff (!rst_b)
    ce && !clear && count == 8'hff |=> count == 8'hff;
  endproperty
  a_timer_sat: assert property (p_timer_sat) else $error("timer wrapped");

  property p_timer_hold;
    @(posedge clk) disable iff (!rst_b)
    ce && !clear && !active |=> $stable(count);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer moved idle");

endmodule
`default_nettype wire

/* hdl/rsm_monitor.sv */
// Purpose: Independent monitor of rail power-up order and slot lengths.
// Assumes: Rail inputs are synchronous levels; slot_boundary pulses once
//          when the sequencer moves to its next slot.
// Notes:   Register port reads answer one cycle after the request.
//
// Function
// - Rail four order in bits six to four.
// - Rail three order in bits two to zero.
// - Same slot same order; advance between slots.
// - Slot one timed independently of the sequencer.
// - Slot lengths are 8-bit counts of ticks.
// - Tick of 100 us from the local clock.
// - Slots two and three timed likewise.
// - Test bit forces the parity check to fail.
// - Buck-boost rail always takes order one.
`timescale 1ns/1ps
`default_nettype none
module rsm_monitor #(
  parameter int TICK_CYCLES = rsm_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire rsm_pkg::rsm_rails_t rails,
  input wire rsm_pkg::rsm_reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic parity_force_fail
);

  typedef struct packed {
    rsm_pkg::rsm_state_t state;
    logic [15:0] tick_cnt;
    logic tick;
    logic [2:0] order;
    logic bb_q;
    logic r3_q;
    logic r4_q;
    logic [2:0] rail3_order_field;
    logic [2:0] rail4_order_field;
    logic force_fail;
    logic [7:0] rdata;
    logic rvalid;
  } rsm_mon_st_t;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  rsm_mon_st_t st;
  rsm_mon_st_t next_st;
  logic start;
  logic [2:0] cur_order;
  logic [2:0] active;
  logic [7:0] slot1_duration_count;
  logic [7:0] slot2_duration_count;
  logic [7:0] slot3_duration_count;

  // The buck-boost rail starting marks a new power-up sequence.
  assign start = rails.buck_boost_rail && !st.bb_q;
  assign cur_order = start ? rsm_pkg::ORDER_FIRST : st.order;

  // A slot is timed while the order counter sits on its number.
  assign active[0] = st.state == rsm_pkg::RSM_RUN && st.order == 3'h1;
  assign active[1] = st.state == rsm_pkg::RSM_RUN && st.order == 3'h2;
  assign active[2] = st.state == rsm_pkg::RSM_RUN && st.order == 3'h3;

  // ****************************************************************
  // Sequence tracking and register port
  // ****************************************************************
  // Next-state logic for order, tick, rail fields and register access.
  always_comb begin
    next_st = st;
    next_st.bb_q = rails.buck_boost_rail;
    next_st.r3_q = rails.linear_rail_three;
    next_st.r4_q = rails.linear_rail_four;
    // Free tick divider, realigned at each sequence start.
    next_st.tick = 1'b0;
    if (start || st.tick_cnt == TICK_LAST) begin
      next_st.tick_cnt = 16'h0000;
      next_st.tick = !start;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end
    case (st.state)
      rsm_pkg::RSM_IDLE: begin
        if (start) begin
          next_st.state = rsm_pkg::RSM_RUN;
          next_st.order = rsm_pkg::ORDER_FIRST;
        end
      end
      rsm_pkg::RSM_RUN: begin
        if (!rails.buck_boost_rail) begin
          next_st.state = rsm_pkg::RSM_IDLE;
          next_st.order = rsm_pkg::ORDER_OFF;
        end else if (rails.slot_boundary && st.order != rsm_pkg::ORDER_MAX) begin
          next_st.order = st.order + 3'h1;
        end
      end
      default: begin
        next_st.state = rsm_pkg::RSM_IDLE;
      end
    endcase
    // Rails take the order of the slot they start in; off reads zero.
    if (!rails.linear_rail_three) begin
      next_st.rail3_order_field = rsm_pkg::ORDER_OFF;
    end else if (!st.r3_q) begin
      next_st.rail3_order_field = cur_order;
    end
    if (!rails.linear_rail_four) begin
      next_st.rail4_order_field = rsm_pkg::ORDER_OFF;
    end else if (!st.r4_q) begin
      next_st.rail4_order_field = cur_order;
    end
    if (req.wr && req.addr == rsm_pkg::ADDR_TEST) begin
      next_st.force_fail = req.wdata[rsm_pkg::FORCE_BIT];
    end
    next_st.rvalid = req.rd;
    next_st.rdata = rsm_pkg::RESET_VALUE;
    if (req.rd) begin
      case (req.addr)
        rsm_pkg::ADDR_ORDER: begin
          next_st.rdata[rsm_pkg::RAIL4_LSB +: 3] = st.rail4_order_field;
          next_st.rdata[rsm_pkg::RAIL3_LSB +: 3] = st.rail3_order_field;
        end
        rsm_pkg::ADDR_SLOT1: next_st.rdata = slot1_duration_count;
        rsm_pkg::ADDR_SLOT2: next_st.rdata = slot2_duration_count;
        rsm_pkg::ADDR_SLOT3: next_st.rdata = slot3_duration_count;
        rsm_pkg::ADDR_TEST: begin
          next_st.rdata[rsm_pkg::FORCE_BIT] = st.force_fail;
        end
        default: next_st.rdata = rsm_pkg::RESET_VALUE;
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.state <= rsm_pkg::RSM_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Slot timers
  // ****************************************************************
  // One timer for each of slots one to three, separate from the sequencer's own timing.
  rsm_slot_timer u_slot1 (
    .clk(clk), .rst_b(rst_b), .ce(ce), .clear(start),
    .active(active[0]), .tick(st.tick), .count(slot1_duration_count)
  );
  rsm_slot_timer u_slot2 (
    .clk(clk), .rst_b(rst_b), .ce(ce), .clear(start),
    .active(active[1]), .tick(st.tick), .count(slot2_duration_count)
  );
  rsm_slot_timer u_slot3 (
    .clk(clk), .rst_b(rst_b), .ce(ce), .clear(start),
    .active(active[2]), .tick(st.tick), .count(slot3_duration_count)
  );

  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign parity_force_fail = st.force_fail;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [9:0] last_addr;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_addr <= 10'h000;
    end else if (ce) begin
      last_addr <= req.addr;
    end
  end

  property p_first_order;
    @(posedge clk) disable iff (!rst_b)
    ce && start |=> st.order == 3'h1 && st.state == rsm_pkg::RSM_RUN;
  endproperty
  a_first_order: assert property (p_first_order) else $error("first order not one");

  property p_order_steady;
    @(posedge clk) disable iff (!rst_b)
    ce && !start && !rails.slot_boundary && rails.buck_boost_rail |=> $stable(st.order);
  endproperty
  a_order_steady: assert property (p_order_steady) else $error("order moved in slot");

  property p_rail3_off;
    @(posedge clk) disable iff (!rst_b)
    ce && !rails.linear_rail_three |=> st.rail3_order_field == 3'h0;
  endproperty
  a_rail3_off: assert property (p_rail3_off) else $error("rail three not zero");

  property p_rail4_take;
    @(posedge clk) disable iff (!rst_b)
    ce && rails.linear_rail_four && !st.r4_q |=> st.rail4_order_field == $past(cur_order);
  endproperty
  a_rail4_take: assert property (p_rail4_take) else $error("rail four order wrong");

  property p_force_write;
    @(posedge clk) disable iff (!rst_b)
    ce && req.wr && req.addr == rsm_pkg::ADDR_TEST |=>
      parity_force_fail == $past(req.wdata[rsm_pkg::FORCE_BIT]);
  endproperty
  a_force_write: assert property (p_force_write) else $error("force bit not written");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b)
    rvalid && last_addr == rsm_pkg::ADDR_ORDER |->
      rdata[7] == 1'b0 && rdata[3] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_tick_alone;
    @(posedge clk) disable iff (!rst_b)
    ce && st.tick |=> !st.tick;
  endproperty
  a_tick_alone: assert property (p_tick_alone) else $error("tick too long");

  property p_slot1_read;
    @(posedge clk) disable iff (!rst_b)
    ce && req.rd && req.addr == rsm_pkg::ADDR_SLOT1 |=>
      rvalid && rdata == $past(slot1_duration_count);
  endproperty
  a_slot1_read: assert property (p_slot1_read) else $error("slot one read wrong");

endmodule
`default_nettype wire

/* verif/testbench.sv */
// Purpose: Self-checking bench for the rail sequence slot monitor.
// Assumes: Inputs change at the falling edge; TICK_CYCLES is cut to 10.
// Notes:   Slot counts are checked with an inclusive window around the ideal.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************************
  // Stimulus and design
  // ****************************************************************
  localparam int TICKS = 10;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  rsm_pkg::rsm_rails_t rails = '0;
  rsm_pkg::rsm_reg_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic parity_force_fail;
  logic [7:0] rd_val;
  int n_errors = 0;
  int n_tests = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  rsm_monitor #(.TICK_CYCLES(TICKS)) rsm_monitor_i (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .rails(rails),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .parity_force_fail(parity_force_fail)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compares one design value with its expected value.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a measured count against an inclusive window.
  task automatic check_rng(input logic [7:0] got, input int lo,
                           input int hi);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Waits the given number of falling edges.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One read: strobe for one cycle, answer sampled one cycle later.
  task automatic reg_rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    n_tests++;
    if (rvalid !== 1'b1) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, rvalid, 1'b1);
    end
    d = rdata;
  endtask

  // Reads a register and compares it in one call.
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    reg_rd(a, rd_val);
    check(rd_val, exp);
  endtask

  // One write strobe of a single cycle.
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Pulses the slot boundary for exactly one cycle.
  task automatic boundary();
    @(negedge clk);
    rails.slot_boundary = 1'b1;
    @(negedge clk);
    rails.slot_boundary = 1'b0;
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  // A hang guard: running out of time counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // Main sequence of tests.
  initial begin
    cyc(8);
    rst_b = 1'b1;
    rd_chk(rsm_pkg::ADDR_ORDER, 8'h00);
    rd_chk(rsm_pkg::ADDR_SLOT1, 8'h00);
    rd_chk(rsm_pkg::ADDR_SLOT2, 8'h00);
    rd_chk(rsm_pkg::ADDR_SLOT3, 8'h00);
    rd_chk(rsm_pkg::ADDR_TEST, 8'h00);
    rd_chk(10'h236, 8'h00);
    check({7'h00, parity_force_fail}, 8'h00);
    $display("test reset values done");
    // Fault injection keeps only bit 0; other writes are ignored.
    reg_wr(rsm_pkg::ADDR_TEST, 8'hff);
    check({7'h00, parity_force_fail}, 8'h01);
    rd_chk(rsm_pkg::ADDR_TEST, 8'h01);
    reg_wr(rsm_pkg::ADDR_SLOT1, 8'h5a);
    rd_chk(rsm_pkg::ADDR_SLOT1, 8'h00);
    reg_wr(rsm_pkg::ADDR_TEST, 8'hfe);
    check({7'h00, parity_force_fail}, 8'h00);
    rd_chk(rsm_pkg::ADDR_TEST, 8'h00);
    $display("test fault injection done");
    // Rail three starts together with the buck-boost rail.
    @(negedge clk);
    rails.buck_boost_rail = 1'b1;
    rails.linear_rail_three = 1'b1;
    cyc(54);
    boundary();
    rails.linear_rail_four = 1'b1;
    cyc(1);
    rd_chk(rsm_pkg::ADDR_ORDER, 8'h21);
    // Slot one ended at the boundary, so the slot one count no longer moves.
    reg_rd(rsm_pkg::ADDR_SLOT1, rd_val);
    check_rng(rd_val, 4, 7);
    cyc(28);
    boundary();
    cyc(3);
    reg_rd(rsm_pkg::ADDR_SLOT2, rd_val);
    check_rng(rd_val, 3, 5);
    reg_rd(rsm_pkg::ADDR_SLOT1, rd_val);
    check_rng(rd_val, 4, 6);
    $display("test order and slot times done");
    // Slot three runs past the top of the count and must stick there.
    cyc(2700);
    boundary();
    rd_chk(rsm_pkg::ADDR_SLOT3, rsm_pkg::COUNT_MAX);
    boundary();
    boundary();
    @(negedge clk);
    rails.linear_rail_three = 1'b0;
    cyc(2);
    rails.linear_rail_three = 1'b1;
    cyc(2);
    rd_chk(rsm_pkg::ADDR_ORDER, 8'h25);
    rd_chk(rsm_pkg::ADDR_SLOT3, rsm_pkg::COUNT_MAX);
    $display("test saturation done");
    // Rails dropping clear their fields; the sequence ends.
    rails.linear_rail_three = 1'b0;
    rails.buck_boost_rail = 1'b0;
    cyc(2);
    rd_chk(rsm_pkg::ADDR_ORDER, 8'h20);
    rails.linear_rail_four = 1'b0;
    rails.linear_rail_three = 1'b1;
    cyc(2);
    rd_chk(rsm_pkg::ADDR_ORDER, 8'h00);
    rails.linear_rail_three = 1'b0;
    $display("test power down done");
    // A new sequence clears the timers; a low enable freezes them.
    cyc(2);
    rails.buck_boost_rail = 1'b1;
    cyc(3);
    ce = 1'b0;
    cyc(100);
    ce = 1'b1;
    rd_chk(rsm_pkg::ADDR_SLOT1, 8'h00);
    rd_chk(rsm_pkg::ADDR_SLOT3, 8'h00);
    rd_chk(rsm_pkg::ADDR_ORDER, 8'h00);
    cyc(10);
    reg_rd(rsm_pkg::ADDR_SLOT1, rd_val);
    check_rng(rd_val, 1, 2);
    $display("test restart done");
    summarize();
  end
endmodule
`default_nettype wire
